// >>> hw/hcl_top.sv
// Hardware configuration low bits with an AXI4-Lite register slave
`timescale 1ns/1ns
// Operation
// - Offset field bits 10:9 pads zero to three bytes before receive data.
// - Loss of sync stalls bulk-out unless bit 8 is set.
// - Bit 7 in internal PHY mode drives MII subset and interrupt pins out.
// - Bit 7 does nothing while an external PHY is selected.
// - Active MII visibility bars its pins from general-purpose use.
// - Bit 6 set discards errored receive frames, clear keeps them.
// - Bit 5 allows several transmit frames per USB packet, else one.
// - Receive path always allows several frames per USB packet.
// - EEPROM time-out is 30 ms with bit 4 clear, 1.28 us set.
// - Writing bit 3 starts lite reset; USB side untouched; clears when done.
// - Read-only bit 2 shows external PHY, defaulting from the strap pin.
// - Bit 1 makes the burst cap limit transfers; clear ignores it.
// - Writing bit 0 starts full reset, resets external PHY, reloads EEPROM.
// - USB PHY stays disconnected during full reset, reconnects afterwards.
// - Boost field takes EEPROM image or zero; USB or lite reset restores it.
// - Boost codes 00 normal, 01 to 11 rising drive steps.
module hcl_top
	import hcl_pkg::*;
#(
	parameter int EE_LONG_CYC = EE_TO_LONG_CYC,
	parameter int LITE_CYC = LITE_RST_CYC,
	parameter int FULL_CYC = FULL_RST_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Straps and datapath events
	input wire logic phy_source_strap,
	input wire logic tx_loss_of_sync,
	input wire logic bulk_out_unstall,
	input wire logic rx_frame_end,
	input wire logic rx_frame_errored,
	input wire logic usb_bus_reset,
	// EEPROM controller
	input wire logic eeprom_present,
	input wire logic eeprom_boost_load,
	input wire logic [1:0] eeprom_boost_image,
	input wire logic eeprom_busy,
	// Configuration and control outputs
	output hcl_cfg_t cfg_out,
	output logic bulk_out_stall,
	output logic mii_pins_drive,
	output logic gpio_mii_barred,
	output logic rx_frame_drop,
	output logic rx_frame_keep,
	output logic tx_single_frame,
	output logic rx_multi_frame,
	output logic eeprom_timeout,
	output logic lite_reset,
	output logic full_reset,
	output logic ext_phy_reset,
	output logic usb_phy_disconnect,
	output logic eeprom_reload
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return a == HW_CFG_OFFSET;
	endfunction

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_fire, wr_hit;
	logic [31:0] wr_bits, cfg_word;

	hcl_cfg_t cfg_r, cfg_nxt;
	hcl_seq_t seq_r, seq_nxt;
	logic phy_ext_r, phy_ext_nxt;
	logic [1:0] boost_img_r, boost_img_nxt;

	// Write commits once both address and data are held and no answer waits
	assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_hit = wr_fire & addr_hit(awaddr_r);
	assign wr_bits = wdata_r & strb_mask(wstrb_r);

	// Live register image; self-clearing bits show the running sequence
	always_comb begin
		cfg_word = '0;
		cfg_word[BIT_BOOST_HI:BIT_BOOST_LO] = cfg_r.hs_drive_strength_level;
		cfg_word[BIT_RXOFF_HI:BIT_RXOFF_LO] = cfg_r.rx_data_offset;
		cfg_word[BIT_STALL_DIS] = cfg_r.bulk_out_stall_disable;
		cfg_word[BIT_MII_VIS] = cfg_r.internal_mii_visibility;
		cfg_word[BIT_DROP] = cfg_r.discard_errored_frames;
		cfg_word[BIT_MULTI] = cfg_r.multi_frame_packing;
		cfg_word[BIT_EE_TO] = cfg_r.eeprom_timeout_select;
		cfg_word[BIT_LITE] = seq_r == SEQ_LITE;
		cfg_word[BIT_PHY_EXT] = phy_ext_r;
		cfg_word[BIT_BURST] = cfg_r.burst_limit_enable;
		cfg_word[BIT_FULL] = seq_r == SEQ_FULL;
	end

	// Channel handshakes; one write and one read in flight at most
	always_comb begin
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid & awready_r) begin
			awaddr_nxt = s_axi_awaddr;
			aw_have_nxt = 1'b1;
		end
		if (s_axi_wvalid & wready_r) begin
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
			w_have_nxt = 1'b1;
		end
		if (bvalid_r & s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (wr_fire) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = addr_hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_r & s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid & arready_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = addr_hit(s_axi_araddr) ? cfg_word : '0;
			rresp_nxt = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		// Ready drops while a beat is held so the master sees back-pressure
		awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
		wready_nxt = ~w_have_nxt & ~bvalid_nxt;
		arready_nxt = ~rvalid_nxt;
	end

	// Bus registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end else begin
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ************************************************************
	// Reset sequencer and EEPROM time-out timers
	// ************************************************************
	logic seq_start, seq_done, ee_start, ee_done, ee_busy_q;
	logic [CNT_W-1:0] seq_len, ee_len;

	// Full reset wins over lite when both are written together
	always_comb begin
		seq_nxt = seq_r;
		seq_start = 1'b0;
		seq_len = CNT_W'(LITE_CYC);
		unique case (seq_r)
			SEQ_IDLE: begin
				if (wr_hit & wr_bits[BIT_FULL]) begin
					seq_nxt = SEQ_FULL;
					seq_start = 1'b1;
					seq_len = CNT_W'(FULL_CYC);
				end else if (wr_hit & wr_bits[BIT_LITE]) begin
					seq_nxt = SEQ_LITE;
					seq_start = 1'b1;
				end
			end
			SEQ_LITE, SEQ_FULL: begin
				if (seq_done) begin
					seq_nxt = SEQ_IDLE;
				end
			end
			default: seq_nxt = SEQ_IDLE;
		endcase
	end

	hcl_timer #(.W(CNT_W)) u_seq_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(seq_start),
		.abort(1'b0),
		.load(seq_len),
		.busy(),
		.done(seq_done)
	);

	// Time-out starts when the controller begins waiting; response aborts it
	assign ee_start = eeprom_busy & ~ee_busy_q;
	assign ee_len = cfg_r.eeprom_timeout_select ? CNT_W'(EE_TO_SHORT_CYC)
		: CNT_W'(EE_LONG_CYC);

	hcl_timer #(.W(CNT_W)) u_ee_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(ee_start),
		.abort(~eeprom_busy),
		.load(ee_len),
		.busy(),
		.done(ee_done)
	);

	// ************************************************************
	// Configuration bits and their effects
	// ************************************************************
	logic stall_r, stall_nxt, mii_r, gpio_bar_r, drop_r, keep_r, single_r;
	logic ee_to_r, lite_r, full_r, ext_rst_r, disc_r, reload_r;
	logic seq_end_full;

	assign seq_end_full = seq_done & (seq_r == SEQ_FULL);

	// Software writes, soft resets and EEPROM image loads
	always_comb begin
		cfg_nxt = cfg_r;
		boost_img_nxt = boost_img_r;
		phy_ext_nxt = phy_ext_r;
		if (eeprom_boost_load) begin
			boost_img_nxt = eeprom_present ? eeprom_boost_image : 2'h0;
			cfg_nxt.hs_drive_strength_level = boost_img_nxt;
		end
		if (wr_hit) begin
			if (wstrb_r[1]) begin
				cfg_nxt.hs_drive_strength_level = wr_bits[BIT_BOOST_HI:BIT_BOOST_LO];
				cfg_nxt.rx_data_offset = wr_bits[BIT_RXOFF_HI:BIT_RXOFF_LO];
				cfg_nxt.bulk_out_stall_disable = wr_bits[BIT_STALL_DIS];
			end
			if (wstrb_r[0]) begin
				cfg_nxt.internal_mii_visibility = wr_bits[BIT_MII_VIS];
				cfg_nxt.discard_errored_frames = wr_bits[BIT_DROP];
				cfg_nxt.multi_frame_packing = wr_bits[BIT_MULTI];
				cfg_nxt.eeprom_timeout_select = wr_bits[BIT_EE_TO];
				cfg_nxt.burst_limit_enable = wr_bits[BIT_BURST];
			end
		end
		// Soft resets return writable bits to defaults; boost to its image
		if (seq_start) begin
			cfg_nxt = CFG_RESET;
			cfg_nxt.hs_drive_strength_level = boost_img_r;
		end else if (usb_bus_reset) begin
			cfg_nxt.hs_drive_strength_level = boost_img_r;
		end
		// Strap is sampled again as the full reset finishes
		if (seq_end_full) begin
			phy_ext_nxt = phy_source_strap;
		end
	end

	// Bulk-out stall; a new loss of sync beats a simultaneous unstall
	always_comb begin
		stall_nxt = stall_r;
		if (bulk_out_unstall) begin
			stall_nxt = 1'b0;
		end
		if (tx_loss_of_sync & ~cfg_r.bulk_out_stall_disable) begin
			stall_nxt = 1'b1;
		end
	end

	// Configuration registers; strap caught while reset is held
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_r <= CFG_RESET;
			boost_img_r <= 2'h0;
			phy_ext_r <= phy_source_strap;
			seq_r <= SEQ_IDLE;
			stall_r <= 1'b0;
			ee_busy_q <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			boost_img_r <= boost_img_nxt;
			phy_ext_r <= phy_ext_nxt;
			seq_r <= seq_nxt;
			stall_r <= stall_nxt;
			ee_busy_q <= eeprom_busy;
		end
	end

	// Registered control outputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mii_r <= 1'b0;
			gpio_bar_r <= 1'b0;
			drop_r <= 1'b0;
			keep_r <= 1'b0;
			single_r <= 1'b1;
			ee_to_r <= 1'b0;
			lite_r <= 1'b0;
			full_r <= 1'b0;
			ext_rst_r <= 1'b0;
			disc_r <= 1'b0;
			reload_r <= 1'b0;
		end else begin
			mii_r <= cfg_r.internal_mii_visibility & ~phy_ext_r;
			gpio_bar_r <= cfg_r.internal_mii_visibility & ~phy_ext_r;
			drop_r <= rx_frame_end & rx_frame_errored & cfg_r.discard_errored_frames;
			keep_r <= rx_frame_end & ~(rx_frame_errored & cfg_r.discard_errored_frames);
			single_r <= ~cfg_r.multi_frame_packing;
			ee_to_r <= ee_done & eeprom_busy;
			lite_r <= seq_nxt == SEQ_LITE;
			full_r <= seq_nxt == SEQ_FULL;
			ext_rst_r <= (seq_nxt == SEQ_FULL) & phy_ext_r;
			disc_r <= seq_nxt == SEQ_FULL;
			reload_r <= seq_end_full;
		end
	end

	// ************************************************************
	// Output wiring
	// ************************************************************
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign cfg_out = cfg_r;
	assign bulk_out_stall = stall_r;
	assign mii_pins_drive = mii_r;
	assign gpio_mii_barred = gpio_bar_r;
	assign rx_frame_drop = drop_r;
	assign rx_frame_keep = keep_r;
	assign tx_single_frame = single_r;
	assign rx_multi_frame = 1'b1; // Constant capability of the receive path
	assign eeprom_timeout = ee_to_r;
	assign lite_reset = lite_r;
	assign full_reset = full_r;
	assign ext_phy_reset = ext_rst_r;
	assign usb_phy_disconnect = disc_r;
	assign eeprom_reload = reload_r;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_stall_set: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_loss_of_sync & ~cfg_r.bulk_out_stall_disable |=> bulk_out_stall)
		else $error("bulk-out not stalled on loss of sync");
	chk_stall_kept_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		~bulk_out_stall & (~tx_loss_of_sync | cfg_r.bulk_out_stall_disable) |=> ~bulk_out_stall)
		else $error("bulk-out stalled without cause");
	chk_mii_external: assert property (@(posedge core_clk) disable iff (sys_rst)
		phy_ext_r & $past(phy_ext_r) |-> ~mii_pins_drive & ~gpio_mii_barred)
		else $error("MII pins driven with external PHY");
	chk_mii_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
		cfg_r.internal_mii_visibility & ~phy_ext_r |=> mii_pins_drive && gpio_mii_barred)
		else $error("MII visibility not applied");
	chk_drop_frame: assert property (@(posedge core_clk) disable iff (sys_rst)
		rx_frame_end & rx_frame_errored |=> rx_frame_drop != rx_frame_keep)
		else $error("errored frame both kept and dropped");
	chk_single_frame: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(cfg_r.multi_frame_packing) |=> ~tx_single_frame)
		else $error("packing enable not applied");
	chk_lite_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(lite_reset) |-> lite_reset [*8] ##[1:40] ~lite_reset)
		else $error("lite reset did not self-clear in time");
	chk_full_disc: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(usb_phy_disconnect) |-> ~full_reset && eeprom_reload)
		else $error("disconnect outlived full reset");
	// A short wait ends in a time-out pulse within 16 cycles unless the wait ends first
	chk_ee_short: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(eeprom_busy) && cfg_r.eeprom_timeout_select
		|-> ##[1:16] (eeprom_timeout || ~eeprom_busy))
		else $error("short EEPROM time-out missed");

endmodule

// >>> shared/hcl_pkg.sv
// Shared constants and types for the hardware configuration low-bits block
package hcl_pkg;

	// ************************************************************
	// Bus map
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] HW_CFG_OFFSET = 12'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// Field positions inside the hardware configuration word
	// ************************************************************
	localparam int BIT_BOOST_HI = 14;
	localparam int BIT_BOOST_LO = 13;
	localparam int BIT_RXOFF_HI = 10;
	localparam int BIT_RXOFF_LO = 9;
	localparam int BIT_STALL_DIS = 8;
	localparam int BIT_MII_VIS = 7;
	localparam int BIT_DROP = 6;
	localparam int BIT_MULTI = 5;
	localparam int BIT_EE_TO = 4;
	localparam int BIT_LITE = 3;
	localparam int BIT_PHY_EXT = 2;
	localparam int BIT_BURST = 1;
	localparam int BIT_FULL = 0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 10;
	localparam int CNT_W = 20;
	localparam int EE_TO_LONG_MS = 30;
	localparam int EE_TO_SHORT_NS = 1280;
	localparam int EE_TO_LONG_CYC = EE_TO_LONG_MS * CLK_MHZ * 1000;
	localparam int EE_TO_SHORT_CYC = (EE_TO_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int LITE_RST_NS = 2000;
	localparam int FULL_RST_NS = 5000;
	localparam int LITE_RST_CYC = (LITE_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int FULL_RST_CYC = (FULL_RST_NS * CLK_MHZ + 999) / 1000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [1:0] hs_drive_strength_level;
		logic [1:0] rx_data_offset;
		logic bulk_out_stall_disable;
		logic internal_mii_visibility;
		logic discard_errored_frames;
		logic multi_frame_packing;
		logic eeprom_timeout_select;
		logic burst_limit_enable;
	} hcl_cfg_t;

	localparam hcl_cfg_t CFG_RESET = '0;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_LITE = 3'b010,
		SEQ_FULL = 3'b100
	} hcl_seq_t;

endpackage

// >>> hw/hcl_timer.sv
// One-shot down counter used for reset sequencing and EEPROM time-out
`timescale 1ns/1ns
module hcl_timer
	import hcl_pkg::*;
#(
	parameter int W = CNT_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [W-1:0] load,
	// Status
	output logic busy,
	output logic done
);

	logic [W-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;

	// Load on start, count down, pulse done when the last cycle passes
	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (start) begin
			cnt_nxt = load;
			busy_nxt = 1'b1;
		end else if (abort) begin
			busy_nxt = 1'b0;
		end else if (busy_r) begin
			cnt_nxt = cnt_r - 1'b1;
			if (cnt_r <= W'(1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = busy_r;
	assign done = done_r;

endmodule

// >>> verif/tb_top.sv
// Self-checking testbench for the hardware configuration low-bits block
`timescale 1ns/1ns
module tb_top;
	import hcl_pkg::*;
	// Shortened counts keep the run brief; the short EEPROM time-out keeps its package count EE_TO_SHORT_CYC
	localparam int EE_LONG = 50;
	localparam int LITE_N = 10;
	localparam int FULL_N = 12;
	localparam int LIMIT = 5000;
	logic core_clk, sys_rst;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, eeprom_boost_image;
	logic phy_source_strap, tx_loss_of_sync, bulk_out_unstall, rx_frame_end, rx_frame_errored;
	logic usb_bus_reset, eeprom_present, eeprom_boost_load, eeprom_busy;
	hcl_cfg_t cfg_out;
	logic bulk_out_stall, mii_pins_drive, gpio_mii_barred, rx_frame_drop, rx_frame_keep;
	logic tx_single_frame, rx_multi_frame, eeprom_timeout, lite_reset, full_reset;
	logic ext_phy_reset, usb_phy_disconnect, eeprom_reload, seen;
	int fails, samples_checked, cycles, n;

	hcl_top #(.EE_LONG_CYC(EE_LONG), .LITE_CYC(LITE_N), .FULL_CYC(FULL_N)) hcl_top_inst (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.phy_source_strap(phy_source_strap), .tx_loss_of_sync(tx_loss_of_sync),
		.bulk_out_unstall(bulk_out_unstall), .rx_frame_end(rx_frame_end),
		.rx_frame_errored(rx_frame_errored), .usb_bus_reset(usb_bus_reset),
		.eeprom_present(eeprom_present), .eeprom_boost_load(eeprom_boost_load),
		.eeprom_boost_image(eeprom_boost_image), .eeprom_busy(eeprom_busy), .cfg_out(cfg_out),
		.bulk_out_stall(bulk_out_stall), .mii_pins_drive(mii_pins_drive),
		.gpio_mii_barred(gpio_mii_barred), .rx_frame_drop(rx_frame_drop),
		.rx_frame_keep(rx_frame_keep), .tx_single_frame(tx_single_frame),
		.rx_multi_frame(rx_multi_frame), .eeprom_timeout(eeprom_timeout),
		.lite_reset(lite_reset), .full_reset(full_reset), .ext_phy_reset(ext_phy_reset),
		.usb_phy_disconnect(usb_phy_disconnect), .eeprom_reload(eeprom_reload)
	);

	// ************************************************************
	// Clock, watchdog and checking helpers
	// ************************************************************
	initial core_clk = 1'h0;
	always #50 core_clk = ~core_clk;

	// A hang ends the run here as a failure
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			summarize();
		end
	end

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	// ************************************************************
	// Bus tasks: payload held until its own ready, response awaited
	// ************************************************************
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge core_clk);
			if (!aw_ok && s_axi_awready === 1'h1) begin
				aw_ok = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w_ok && s_axi_wready === 1'h1) begin
				w_ok = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge core_clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk_word("rdata", exp, s_axi_rdata);
		chk_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge core_clk);
	endtask

	// Waits out a soft reset sequence and notes any reload pulse
	task automatic wait_seq();
		seen = 1'h0;
		while (lite_reset === 1'h1 || full_reset === 1'h1) begin
			@(posedge core_clk);
			seen = seen | (eeprom_reload === 1'h1);
		end
		repeat (3) begin
			@(posedge core_clk);
			seen = seen | (eeprom_reload === 1'h1);
		end
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{tx_loss_of_sync, bulk_out_unstall, rx_frame_end, rx_frame_errored} = '0;
		{usb_bus_reset, eeprom_present, eeprom_boost_load, eeprom_busy} = '0;
		eeprom_boost_image = 2'h0;
		phy_source_strap = 1'h1;
		fails = 0;
		samples_checked = 0;
		cycles = 0;
		sys_rst = 1'h1;
		tick(5);
		sys_rst <= 1'h0;
		tick(1);
		rd(HW_CFG_OFFSET, 32'h0000_0004, RESP_OKAY);
		chk_bit("tx_single", 1'h1, tx_single_frame);
		// All plain bits set, then a lane-0-only write clears just the low byte
		wr(HW_CFG_OFFSET, 32'h0000_67F2, 4'hF, RESP_OKAY);
		rd(HW_CFG_OFFSET, 32'h0000_67F6, RESP_OKAY);
		chk_word("cfg", 32'h0000_03FF, {22'h0, cfg_out});
		chk_bit("tx_single", 1'h0, tx_single_frame);
		chk_bit("rx_multi", 1'h1, rx_multi_frame);
		chk_bit("mii_ext", 1'h0, mii_pins_drive);
		wr(HW_CFG_OFFSET, 32'h0, 4'h1, RESP_OKAY);
		rd(HW_CFG_OFFSET, 32'h0000_6704, RESP_OKAY);
		// Unmapped place is refused and leaves the register alone
		wr(12'h010, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		rd(12'h010, 32'h0, RESP_SLVERR);
		rd(HW_CFG_OFFSET, 32'h0000_6704, RESP_OKAY);
		// Every offset and boost code; offset is only changed with receive idle
		for (int i = 0; i < 4; i++) begin
			d = (32'(i) << 13) | (32'(i) << 9);
			wr(HW_CFG_OFFSET, d, 4'hF, RESP_OKAY);
			rd(HW_CFG_OFFSET, d | 32'h4, RESP_OKAY);
			chk_word("offset", 32'(i), {30'h0, cfg_out.rx_data_offset});
		end
		// Stall on loss of sync unless disabled
		for (int m = 0; m < 2; m++) begin
			wr(HW_CFG_OFFSET, m ? 32'h100 : 32'h0, 4'hF, RESP_OKAY);
			tx_loss_of_sync <= 1'h1;
			tick(1);
			tx_loss_of_sync <= 1'h0;
			tick(1);
			chk_bit("stall", m == 0, bulk_out_stall);
			bulk_out_unstall <= 1'h1;
			tick(1);
			bulk_out_unstall <= 1'h0;
			tick(1);
			chk_bit("unstall", 1'h0, bulk_out_stall);
		end
		// Errored frame dropped only with discard set
		for (int m = 0; m < 2; m++) begin
			wr(HW_CFG_OFFSET, m ? 32'h0 : 32'h40, 4'hF, RESP_OKAY);
			rx_frame_end <= 1'h1;
			rx_frame_errored <= 1'h1;
			tick(1);
			rx_frame_end <= 1'h0;
			rx_frame_errored <= 1'h0;
			tick(1);
			chk_bit("drop", m == 0, rx_frame_drop);
			chk_bit("keep", m == 1, rx_frame_keep);
		end
		// EEPROM wait: short then long time-out, then an aborted wait
		for (int m = 0; m < 2; m++) begin
			wr(HW_CFG_OFFSET, m ? 32'h0 : 32'h10, 4'hF, RESP_OKAY);
			eeprom_busy <= 1'h1;
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (eeprom_timeout !== 1'h1 && n < 200);
			eeprom_busy <= 1'h0;
			tick(1);
			n = n - (m ? EE_LONG : EE_TO_SHORT_CYC);
			chk_bit("ee_time", 1'h1, n >= 0 && n <= 5);
		end
		eeprom_busy <= 1'h1;
		tick(5);
		eeprom_busy <= 1'h0;
		seen = 1'h0;
		repeat (70) begin
			@(posedge core_clk);
			seen = seen | (eeprom_timeout === 1'h1);
		end
		chk_bit("ee_abort", 1'h0, seen);
		// Boost image loaded, then lite reset restores it
		eeprom_present <= 1'h1;
		eeprom_boost_image <= 2'h2;
		eeprom_boost_load <= 1'h1;
		tick(1);
		eeprom_boost_load <= 1'h0;
		wr(HW_CFG_OFFSET, 32'h0000_6020, 4'hF, RESP_OKAY);
		wr(HW_CFG_OFFSET, 32'h0000_0008, 4'h1, RESP_OKAY);
		rd(HW_CFG_OFFSET, 32'h0000_400C, RESP_OKAY);
		chk_bit("lite", 1'h1, lite_reset);
		chk_bit("lite_usb", 1'h0, usb_phy_disconnect);
		wait_seq();
		chk_bit("lite_reload", 1'h0, seen);
		rd(HW_CFG_OFFSET, 32'h0000_4004, RESP_OKAY);
		// USB reset brings the boost field back to the image
		wr(HW_CFG_OFFSET, 32'h0000_2000, 4'hF, RESP_OKAY);
		usb_bus_reset <= 1'h1;
		tick(1);
		usb_bus_reset <= 1'h0;
		tick(2);
		chk_word("boost", 32'h2, {30'h0, cfg_out.hs_drive_strength_level});
		// Full reset with an external PHY; strap changes before its end
		wr(HW_CFG_OFFSET, 32'h0000_0001, 4'h1, RESP_OKAY);
		rd(HW_CFG_OFFSET, 32'h0000_4005, RESP_OKAY);
		chk_bit("full", 1'h1, full_reset);
		chk_bit("disconnect", 1'h1, usb_phy_disconnect);
		chk_bit("ext_phy_rst", 1'h1, ext_phy_reset);
		phy_source_strap <= 1'h0;
		wait_seq();
		chk_bit("reload", 1'h1, seen);
		chk_bit("reconnect", 1'h0, usb_phy_disconnect);
		rd(HW_CFG_OFFSET, 32'h0000_4000, RESP_OKAY);
		// Internal PHY now: visibility drives the pins and bars general use
		for (int m = 0; m < 2; m++) begin
			wr(HW_CFG_OFFSET, m ? 32'h0 : 32'h80, 4'hF, RESP_OKAY);
			tick(2);
			chk_bit("mii_drive", m == 0, mii_pins_drive);
			chk_bit("gpio_bar", m == 0, gpio_mii_barred);
		end
		summarize();
	end
endmodule
